// ==== ebr_pkg.sv ====
package ebr_pkg;
	// Geometry: 512 rows of four 9-bit lanes, 8 data bits plus one parity bit each.
	localparam int ADDR_W    = 14;
	localparam int DATA_W    = 36;
	localparam int LANES     = 4;
	localparam int LANE_W    = 9;
	localparam int ROWS      = 512;
	localparam int ROW_W     = 9;
	localparam int LSB_W     = 6;
	localparam int TOTAL_BITS = 18432;

	typedef enum logic [2:0] {
		WID_1  = 3'h0,
		WID_2  = 3'h1,
		WID_4  = 3'h2,
		WID_9  = 3'h3,
		WID_18 = 3'h4,
		WID_36 = 3'h5
	} width_e;

	typedef enum logic [1:0] {
		MODE_SINGLE      = 2'h0,
		MODE_TRUE_DUAL   = 2'h1,
		MODE_PSEUDO_DUAL = 2'h3,
		MODE_ROM         = 2'h2
	} mode_e;

	localparam logic [7:0]  CFG_OFS      = 8'h00;
	localparam logic [7:0]  STAT_OFS     = 8'h04;
	localparam int          CFG_MODE_LSB = 0;
	localparam int          CFG_WA_LSB   = 4;
	localparam int          CFG_WB_LSB   = 8;
	localparam int          CFG_OREG_A   = 12;
	localparam int          CFG_OREG_B   = 13;
	localparam int          CFG_PARGEN   = 14;
	localparam int          CFG_LOCK     = 15;
	localparam logic [31:0] CFG_RESET    = 32'h0000_0330;
	localparam int          STAT_PERR_A  = 0;
	localparam int          STAT_PERR_B  = 1;
	localparam int          STAT_LOCKED  = 2;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// ==== ebr_lane_if.sv ====
`timescale 1ns/1ps
interface ebr_lane_if;
	import ebr_pkg::*;
	logic [ROW_W-1:0]  row;
	logic [LSB_W-1:0]  lsb;
	logic [DATA_W-1:0] fieldMask;
	logic [DATA_W-1:0] wrMask;
	logic [DATA_W-1:0] wrData;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] rowData;
	modport front (output row, lsb, fieldMask, wrMask, wrData, wr, rd);
	modport array (input row, wrMask, wrData, wr, output rowData);
	modport rdpath (input lsb, fieldMask, rd, rowData);
endinterface // ebr_lane_if

// ==== ebr_port_front.sv ====
`timescale 1ns/1ps
module ebr_port_front
	import ebr_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  en,
	input  wire logic                  we,
	input  wire logic [ADDR_W-1:0]     addr,
	input  wire logic [DATA_W-1:0]     wdata,
	input  wire logic [LANES-1:0]      byteEn,
	input  wire ebr_pkg::width_e       width,
	input  wire logic                  wrAllow,
	input  wire logic                  rdAllow,
	input  wire logic                  parityGen,
	ebr_lane_if.front                  lane
);
	logic                 en_r;
	logic                 we_r;
	logic [ADDR_W-1:0]    addr_r;
	logic [DATA_W-1:0]    wdata_r;
	logic [LANES-1:0]     byteEn_r;
	logic [1:0]           bank;
	logic [2:0]           off;
	logic [LANES-1:0]     be;
	logic [DATA_W-1:0]    beMask;
	logic [DATA_W-1:0]    wd;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			en_r     <= 1'b0;
			we_r     <= 1'b0;
			addr_r   <= '0;
			wdata_r  <= '0;
			byteEn_r <= '0;
		end else begin
			en_r     <= en;
			we_r     <= we;
			addr_r   <= addr;
			wdata_r  <= wdata;
			byteEn_r <= byteEn;
		end
	end

	// Narrow words use only the eight data bits of a lane, so parity bits stay unreachable.
	always_comb begin
		bank           = 2'h0;
		off            = 3'h0;
		be             = 4'hf;
		lane.row       = addr_r[8:0];
		lane.fieldMask = {DATA_W{1'b1}};
		case (width)
			WID_1: begin
				lane.row       = addr_r[13:5];
				bank           = addr_r[4:3];
				off            = addr_r[2:0];
				lane.fieldMask = 36'h0_0000_0001;
			end
			WID_2: begin
				lane.row       = addr_r[12:4];
				bank           = addr_r[3:2];
				off            = {addr_r[1:0], 1'b0};
				lane.fieldMask = 36'h0_0000_0003;
			end
			WID_4: begin
				lane.row       = addr_r[11:3];
				bank           = addr_r[2:1];
				off            = {addr_r[0], 2'b00};
				lane.fieldMask = 36'h0_0000_000f;
			end
			WID_9: begin
				lane.row       = addr_r[10:2];
				bank           = addr_r[1:0];
				lane.fieldMask = 36'h0_0000_01ff;
			end
			WID_18: begin
				lane.row       = addr_r[9:1];
				bank           = {addr_r[0], 1'b0};
				be             = {2'b00, byteEn_r[1:0]};
				lane.fieldMask = 36'h0_0003_ffff;
			end
			default: begin
				be = byteEn_r;
			end
		endcase
	end

	assign lane.lsb = LSB_W'({4'h0, bank}) * 6'h09 + {3'h0, off};
	assign beMask   = {{LANE_W{be[3]}}, {LANE_W{be[2]}}, {LANE_W{be[1]}}, {LANE_W{be[0]}}};

	always_comb begin
		wd = wdata_r;
		if (parityGen && width >= WID_9) begin
			for (int k = 0; k < LANES; k++) begin
				wd[k*LANE_W+8] = ^wdata_r[k*LANE_W +: 8];
			end
		end
	end

	assign lane.wrMask = (lane.fieldMask & beMask) << lane.lsb;
	assign lane.wrData = (wd & lane.fieldMask) << lane.lsb;
	assign lane.wr     = en_r & we_r & wrAllow;
	assign lane.rd     = en_r & ~we_r & rdAllow;
endmodule // ebr_port_front

// ==== ebr_read_path.sv ====
`timescale 1ns/1ps
module ebr_read_path
	import ebr_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire ebr_pkg::width_e       width,
	input  wire logic                  outReg,
	input  wire logic                  parityGen,
	ebr_lane_if.rdpath                 lane,
	output logic [DATA_W-1:0]          rdata,
	output logic                       parityErr
);
	logic [DATA_W-1:0] word;
	logic [LANES-1:0]  bad;
	logic [DATA_W-1:0] q_r;
	logic [DATA_W-1:0] qOut_r;
	logic              pErr_r;

	assign word = (lane.rowData >> lane.lsb) & lane.fieldMask;

	always_comb begin
		bad = '0;
		for (int k = 0; k < LANES; k++) begin
			bad[k] = lane.fieldMask[k*LANE_W] & (word[k*LANE_W+8] != ^word[k*LANE_W +: 8]);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q_r    <= '0;
			qOut_r <= '0;
			pErr_r <= 1'b0;
		end else begin
			if (lane.rd) begin
				q_r <= word;
			end
			qOut_r <= q_r;
			pErr_r <= lane.rd & parityGen & (width >= WID_9) & (|bad);
		end
	end

	// The output stage is chosen statically, so the mux never glitches in service.
	assign rdata     = outReg ? qOut_r : q_r;
	assign parityErr = pErr_r;
endmodule // ebr_read_path

// ==== embedded_block_ram.sv ====
`timescale 1ns/1ps
// Overview of operation
// - 18-Kbit array with input and output registers.
// - Single, true dual, pseudo dual; 36 not true-dual.
// - Optional parity bit stored per data byte at 9, 18 and 36 bits.
// - Byte enables honoured at 18 and 36 bits.
// - Each port has its own data width.
// - Word zero occupies lowest bits, per port width.
// - Preloaded contents; writes disabled gives read-only memory.
// - Address and write data registered at array input.
// - Optional output register adds one clock.
// - Normal mode: output changes only on reads.
module embedded_block_ram
	import ebr_pkg::*;
#(
	parameter int               AXI_ADDR_W = 8,
	parameter logic [LANE_W-1:0] INIT_FILL = 9'h000
) (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic [AXI_ADDR_W-1:0] awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [AXI_ADDR_W-1:0] araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire logic                  aEn,
	input  wire logic                  aWe,
	input  wire logic [ebr_pkg::ADDR_W-1:0] aAddr,
	input  wire logic [ebr_pkg::DATA_W-1:0] aWdata,
	input  wire logic [ebr_pkg::LANES-1:0]  aByteEn,
	output logic [ebr_pkg::DATA_W-1:0]      aRdata,
	input  wire logic                  bEn,
	input  wire logic                  bWe,
	input  wire logic [ebr_pkg::ADDR_W-1:0] bAddr,
	input  wire logic [ebr_pkg::DATA_W-1:0] bWdata,
	input  wire logic [ebr_pkg::LANES-1:0]  bByteEn,
	output logic [ebr_pkg::DATA_W-1:0]      bRdata
);
	if (AXI_ADDR_W < 3) begin : g_chk_addr
		$error("AXI_ADDR_W must be at least 3");
	end
	if (ROWS * DATA_W != TOTAL_BITS) begin : g_chk_size
		$error("array geometry must total 18432 bits");
	end
	if (LANES * LANE_W != DATA_W) begin : g_chk_lanes
		$error("lanes must fill the data word exactly");
	end
	if ((1 << ROW_W) != ROWS) begin : g_chk_rows
		$error("row address width does not match the row count");
	end
	if (ADDR_W != ROW_W + 5) begin : g_chk_addr_w
		$error("word address must add five bits to the row address");
	end
	if ((1 << LSB_W) < (LANES - 1) * LANE_W + 8) begin : g_chk_lsb
		$error("bit offset field too narrow for the widest shift");
	end
	if (CFG_RESET[CFG_WA_LSB +: 3] > 3'h5 || CFG_RESET[CFG_WB_LSB +: 3] > 3'h5) begin : g_chk_rst
		$error("reset configuration must name legal widths");
	end

	// Register slave state.
	logic                  awHeld_r;
	logic [AXI_ADDR_W-1:0] awAddr_r;
	logic                  wHeld_r;
	logic [31:0]           wData_r;
	logic [3:0]            wStrb_r;
	logic                  bvalid_r;
	logic [1:0]            bresp_r;
	logic                  rvalid_r;
	logic [31:0]           rdata_r;
	logic [1:0]            rresp_r;
	logic [31:0]           cfg_r;
	logic                  perrA_r;
	logic                  perrB_r;

	// Decode and configuration wires.
	wire                   doWrite  = awHeld_r & wHeld_r & ~bvalid_r;
	wire                   arFire   = arvalid & arready;
	wire [7:0]             wrOfs    = 8'(awAddr_r) & 8'hfc;
	wire [7:0]             rdOfs    = 8'(araddr) & 8'hfc;
	wire                   wrCfg    = doWrite & (wrOfs == CFG_OFS);
	wire                   wrStat   = doWrite & (wrOfs == STAT_OFS);
	wire                   locked   = cfg_r[CFG_LOCK];
	logic [31:0]           cfgMerged;
	logic [31:0]           statWord;
	logic                  cfgLegal;
	logic                  wrOk;

	mode_e                 mode;
	width_e                widthA;
	width_e                widthB;
	mode_e                 newMode;
	width_e                newWa;
	width_e                newWb;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			cfgMerged[i*8 +: 8] = wStrb_r[i] ? wData_r[i*8 +: 8] : cfg_r[i*8 +: 8];
		end
	end

	assign mode    = mode_e'(cfg_r[CFG_MODE_LSB +: 2]);
	assign widthA  = width_e'(cfg_r[CFG_WA_LSB +: 3]);
	assign widthB  = width_e'(cfg_r[CFG_WB_LSB +: 3]);
	assign newMode = mode_e'(cfgMerged[CFG_MODE_LSB +: 2]);
	assign newWa   = width_e'(cfgMerged[CFG_WA_LSB +: 3]);
	assign newWb   = width_e'(cfgMerged[CFG_WB_LSB +: 3]);

	// A rejected configuration leaves the previous setting in force and answers SLVERR.
	assign cfgLegal = (newWa <= WID_36) && (newWb <= WID_36) && !locked &&
		!(newMode == MODE_TRUE_DUAL && (newWa == WID_36 || newWb == WID_36));

	assign wrOk = (wrCfg & cfgLegal) | wrStat;

	assign statWord = {29'h0, locked, perrB_r, perrA_r};

	// Handshake outputs are holding flops or their plain inverses, so they never glitch.
	assign awready = ~awHeld_r;
	assign wready  = ~wHeld_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = ~rvalid_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;

	// Address and data may arrive in either order; the write is done once both are held and
	// no response still stands, so a slow bready simply stalls the next write.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			awHeld_r <= 1'b0;
			awAddr_r <= '0;
			wHeld_r  <= 1'b0;
			wData_r  <= '0;
			wStrb_r  <= '0;
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= awaddr;
			end else if (doWrite) begin
				awHeld_r <= 1'b0;
			end
			if (wvalid && wready) begin
				wHeld_r <= 1'b1;
				wData_r <= wdata;
				wStrb_r <= wstrb;
			end else if (doWrite) begin
				wHeld_r <= 1'b0;
			end
			if (doWrite) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wrOk ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// A new read address is refused while a response stands, so rdata never moves under it.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= RESP_OKAY;
		end else if (arFire) begin
			rvalid_r <= 1'b1;
			rdata_r  <= (rdOfs == CFG_OFS) ? cfg_r : (rdOfs == STAT_OFS) ? statWord : 32'h0;
			rresp_r  <= (rdOfs == CFG_OFS || rdOfs == STAT_OFS) ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Configuration word: mode in [1:0], port widths in [6:4] and [10:8], output registers
	// in [13:12], parity in [14] and lock in [15]. Once lock is set only a reset reopens it,
	// so a stray write from a faulty master cannot retune a memory that is in service.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r <= CFG_RESET;
		end else if (wrCfg && cfgLegal) begin
			cfg_r <= cfgMerged & 32'h0000_f773;
		end
	end

	logic perrA;
	logic perrB;

	// A new error in the clearing cycle keeps its flag set.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			perrA_r <= 1'b0;
			perrB_r <= 1'b0;
		end else begin
			perrA_r <= perrA | (perrA_r & ~(wrStat & wStrb_r[0] & wData_r[STAT_PERR_A]));
			perrB_r <= perrB | (perrB_r & ~(wrStat & wStrb_r[0] & wData_r[STAT_PERR_B]));
		end
	end

	// Port roles per mode: pseudo dual writes on A and reads on B; read-only mode reads both.
	// A refused request raises no flag; it simply leaves the array and the read word alone.
	wire aWrAllow = (mode == MODE_SINGLE) | (mode == MODE_TRUE_DUAL) |
		(mode == MODE_PSEUDO_DUAL);
	wire aRdAllow = (mode != MODE_PSEUDO_DUAL);
	wire bWrAllow = (mode == MODE_TRUE_DUAL);
	wire bRdAllow = (mode != MODE_SINGLE);
	wire parGen   = cfg_r[CFG_PARGEN];

	ebr_lane_if laneA ();
	ebr_lane_if laneB ();

	// Each port registers its own request; the array only ever sees the registered copies.
	ebr_port_front u_frontA (
		.clk       (clk),
		.rst_b     (rst_b),
		.en        (aEn),
		.we        (aWe),
		.addr      (aAddr),
		.wdata     (aWdata),
		.byteEn    (aByteEn),
		.width     (widthA),
		.wrAllow   (aWrAllow),
		.rdAllow   (aRdAllow),
		.parityGen (parGen),
		.lane      (laneA.front)
	);

	ebr_port_front u_frontB (
		.clk       (clk),
		.rst_b     (rst_b),
		.en        (bEn),
		.we        (bWe),
		.addr      (bAddr),
		.wdata     (bWdata),
		.byteEn    (bByteEn),
		.width     (widthB),
		.wrAllow   (bWrAllow),
		.rdAllow   (bRdAllow),
		.parityGen (parGen),
		.lane      (laneB.front)
	);

	// Storage: four 9-bit lanes per row, 18432 bits in all.
	// The preload is a declaration value, not a process, so the write process below stays
	// the only writer of the array; reset never touches the contents.
	logic [DATA_W-1:0] mem [ROWS] = '{default: {LANES{INIT_FILL}}};

	wire [DATA_W-1:0] wrBitsA = {DATA_W{laneA.wr}} & laneA.wrMask;
	wire [DATA_W-1:0] wrBitsB = {DATA_W{laneB.wr}} & laneB.wrMask;

	// Port A is applied last, so it wins a same-bit collision; reads see the old word.
	always_ff @(posedge clk) begin
		for (int i = 0; i < DATA_W; i++) begin
			if (wrBitsB[i]) begin
				mem[laneB.row][i] <= laneB.wrData[i];
			end
			if (wrBitsA[i]) begin
				mem[laneA.row][i] <= laneA.wrData[i];
			end
		end
	end

	assign laneA.rowData = mem[laneA.row];
	assign laneB.rowData = mem[laneB.row];

	// Each read path keeps its word until the next read on its own port.
	ebr_read_path u_readA (
		.clk       (clk),
		.rst_b     (rst_b),
		.width     (widthA),
		.outReg    (cfg_r[CFG_OREG_A]),
		.parityGen (parGen),
		.lane      (laneA.rdpath),
		.rdata     (aRdata),
		.parityErr (perrA)
	);

	ebr_read_path u_readB (
		.clk       (clk),
		.rst_b     (rst_b),
		.width     (widthB),
		.outReg    (cfg_r[CFG_OREG_B]),
		.parityGen (parGen),
		.lane      (laneB.rdpath),
		.rdata     (bRdata),
		.parityErr (perrB)
	);
endmodule // embedded_block_ram

// ==== embedded_block_ram_checker.sv ====
`timescale 1ns/1ps
module embedded_block_ram_checker
#(
	parameter int AXI_ADDR_W = 8
) (
	input wire logic                        clk,
	input wire logic                        rst_b,
	input wire logic                        awvalid,
	input wire logic                        awready,
	input wire logic                        wvalid,
	input wire logic                        wready,
	input wire logic [1:0]                  bresp,
	input wire logic                        bvalid,
	input wire logic                        bready,
	input wire logic [AXI_ADDR_W-1:0]       araddr,
	input wire logic                        arvalid,
	input wire logic                        arready,
	input wire logic [31:0]                 rdata,
	input wire logic [1:0]                  rresp,
	input wire logic                        rvalid,
	input wire logic                        rready,
	input wire logic                        aEn,
	input wire logic                        aWe,
	input wire logic [ebr_pkg::DATA_W-1:0]  aRdata
);
	import ebr_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// A read sampled at one edge moves the word one edge later, or two with the output
	// register, so two quiet request cycles leave the word alone at the edge after the next.
	chk_a_quiet: assert property (
		!(aEn && !aWe) && !($past(aEn) && !$past(aWe)) |-> ##2 $stable(aRdata))
		else $error("port A read word changed without a read");
	chk_b_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped or changed before taken");
	chk_b_answer: assert property (
		awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
		else $error("write response late");
	chk_r_hold: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read response dropped or changed before taken");
	chk_r_cause: assert property (
		$rose(rvalid) |-> $past(arvalid) && $past(arready))
		else $error("read response without a read address");
	chk_r_answer: assert property (
		arvalid && arready |=> rvalid)
		else $error("read response late");
	chk_unmapped_read: assert property (
		arvalid && arready && araddr[AXI_ADDR_W-1:2] > 1
		|=> rresp == RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_cfg_zeros: assert property (
		arvalid && arready && araddr[AXI_ADDR_W-1:2] == 0
		|=> rdata[31:16] == 16'h0 && rdata[3:2] == 2'h0 && !rdata[7] && !rdata[11])
		else $error("unused config bits read nonzero");
endmodule // embedded_block_ram_checker

bind embedded_block_ram embedded_block_ram_checker #(.AXI_ADDR_W(AXI_ADDR_W)) i_chk (
	.clk, .rst_b, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
	.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .aEn, .aWe, .aRdata);

// ==== fabric_port_model.sv ====
`timescale 1ns/1ps
module fabric_port_model (
	input  wire logic                       clk,
	output logic                            en,
	output logic                            we,
	output logic [ebr_pkg::ADDR_W-1:0]      addr,
	output logic [ebr_pkg::DATA_W-1:0]      wdata,
	output logic [ebr_pkg::LANES-1:0]       byteEn,
	output logic                            look
);
	import ebr_pkg::*;
	initial begin
		en = 1'b0;
		we = 1'b0;
		addr = '0;
		wdata = '0;
		byteEn = '0;
		look = 1'b0;
	end

	// One request per call; look marks the cycle in which the answer must be seen.
	task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [LANES-1:0] be, input int lat, input logic chk);
		@(posedge clk);
		en <= 1'b1;
		we <= w;
		addr <= a;
		wdata <= d;
		byteEn <= be;
		@(posedge clk);
		en <= 1'b0;
		// Released lines wander, so a stale address or word can never pass for a good one.
		addr <= ~a;
		wdata <= ~d;
		byteEn <= ~be;
		repeat (lat) @(posedge clk);
		look <= chk;
		@(posedge clk);
		look <= 1'b0;
	endtask
endmodule // fabric_port_model

// ==== test_embedded_block_ram.sv ====
`timescale 1ns/1ps
module test_embedded_block_ram;
	import ebr_pkg::*;
	typedef struct {
		string       what;
		logic [35:0] val;
	} note_s;
	localparam logic [8:0] FILL = 9'h1a5;
	logic        clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, lookA, lookB, aEn, aWe, bEn, bWe;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, aByteEn, bByteEn;
	logic [1:0]  bresp, rresp;
	logic [13:0] aAddr, bAddr;
	logic [35:0] aWdata, bWdata, aRdata, bRdata;
	note_s       q[$];
	int          n_fail, check_count, latB;
	int          wid[6] = '{1, 2, 4, 9, 18, 36};

	embedded_block_ram #(.INIT_FILL(FILL)) i_dut (.clk, .rst_b, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .aEn, .aWe, .aAddr, .aWdata, .aByteEn,
		.aRdata, .bEn, .bWe, .bAddr, .bWdata, .bByteEn, .bRdata);
	fabric_port_model i_fabA (.clk, .en(aEn), .we(aWe), .addr(aAddr), .wdata(aWdata),
		.byteEn(aByteEn), .look(lookA));
	fabric_port_model i_fabB (.clk, .en(bEn), .we(bWe), .addr(bAddr), .wdata(bWdata),
		.byteEn(bByteEn), .look(lookB));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic end_sim();
		n_fail += q.size();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic push(input string s, input logic [35:0] v);
		note_s n;
		n.what = s;
		n.val = v;
		q.push_back(n);
	endtask

	task automatic note(input logic [35:0] seen);
		note_s e;
		check_count++;
		if (q.size() == 0) begin
			n_fail++;
			$display("mismatch unexpected expected none seen %h", seen);
		end else begin
			e = q.pop_front();
			if (e.val !== seen) begin
				n_fail++;
				$display("mismatch %s expected %h seen %h", e.what, e.val, seen);
			end
		end
	endtask

	// Sampled half a period before the edge, so the value is the one that edge will see.
	always @(negedge clk) begin
		if (bvalid && bready)
			note({34'h0, bresp});
		if (rvalid && rready) begin
			note({4'h0, rdata});
			note({34'h0, rresp});
		end
		if (lookA)
			note(aRdata);
		if (lookB)
			note(bRdata);
	end

	function automatic logic [31:0] cfgw(input logic [1:0] m, input logic [2:0] wa,
		input logic [2:0] wb, input logic ob, input logic par);
		return {16'h0, 1'b0, par, ob, 2'h0, wb, 1'b0, wa, 2'h0, m};
	endfunction

	function automatic logic [35:0] fixPar(input logic [35:0] v);
		for (int i = 0; i < 4; i++)
			v[9 * i + 8] = ^v[9 * i +: 8];
		return v;
	endfunction

	// Narrow words sit inside the 8 data bits of a lane and skip its ninth bit.
	function automatic logic [35:0] slice(input logic [35:0] x, input int w, input int j);
		int base;
		base = (w < 9) ? (j / (8 / w)) * 9 + (j % (8 / w)) * w : j * w;
		return (x >> base) & ((36'h1 << w) - 36'h1);
	endfunction

	task automatic axiW(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aP, wP, bP;
		int   n;
		push("bresp", {34'h0, r});
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		{aP, wP, bP} = 3'h7;
		for (n = 0; n < 100 && (aP || wP || bP); n++) begin
			@(negedge clk);
			aP = aP && !awready;
			wP = wP && !wready;
			bP = bP && !bvalid;
			@(posedge clk);
			if (!aP)
				awvalid <= 1'b0;
			if (!wP)
				wvalid <= 1'b0;
			if (!bP)
				bready <= 1'b0;
		end
		if (n == 100) begin
			n_fail++;
			end_sim();
		end
	endtask

	task automatic axiR(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aP, rP;
		int   n;
		push("rdata", {4'h0, d});
		push("rresp", {34'h0, r});
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		{aP, rP} = 2'h3;
		for (n = 0; n < 100 && (aP || rP); n++) begin
			@(negedge clk);
			aP = aP && !arready;
			rP = rP && !rvalid;
			@(posedge clk);
			if (!aP)
				arvalid <= 1'b0;
			if (!rP)
				rready <= 1'b0;
		end
		if (n == 100) begin
			n_fail++;
			end_sim();
		end
	endtask

	task automatic op(input logic p, input logic w, input logic [13:0] a, input logic [35:0] d,
		input logic [3:0] be, input logic chk, input logic [35:0] e);
		if (chk)
			push(p ? "bRdata" : "aRdata", e);
		if (p)
			i_fabB.access(w, a, d, be, latB, chk);
		else
			i_fabA.access(w, a, d, be, 1, chk);
	endtask

	initial begin
		logic [35:0] x, y, m;
		int          k, w, j;
		{rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		latB = 1;
		void'($urandom(32'h469c));
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		axiR(8'h00, cfgw(2'h0, 3'h3, 3'h3, 1'b0, 1'b0), RESP_OKAY);
		axiR(8'h0c, 32'h0, RESP_SLVERR);
		axiW(8'h00, cfgw(2'h0, 3'h6, 3'h3, 1'b0, 1'b0), RESP_SLVERR);
		$display("test registers done");
		x = {27'h0, 9'($urandom)};
		op(0, 1, 14'h5, x, 4'hf, 0, 0);
		op(0, 0, 14'h5, 0, 4'hf, 1, x);
		op(0, 1, 14'h6, ~x, 4'hf, 1, x);
		op(0, 0, 14'h7, 0, 4'hf, 1, {27'h0, FILL});
		op(1, 0, 14'h5, 0, 4'hf, 1, 0);
		$display("test single port done");
		axiW(8'h00, cfgw(2'h0, 3'h5, 3'h3, 1'b0, 1'b0), RESP_OKAY);
		x = {$urandom, 4'($urandom)};
		y = {$urandom, 4'($urandom)};
		m = {9'h0, 9'h1ff, 9'h0, 9'h1ff};
		op(0, 1, 14'h3, x, 4'hf, 0, 0);
		op(0, 1, 14'h3, y, 4'h5, 0, 0);
		x = (x & ~m) | (y & m);
		op(0, 0, 14'h3, 0, 4'hf, 1, x);
		$display("test byte enables done");
		latB = 2;
		for (k = 0; k < 6; k++) begin
			w = wid[k];
			y = {$urandom, 4'($urandom)};
			axiW(8'h00, cfgw(2'h3, 3'h5, 3'(k), 1'b1, 1'b1), RESP_OKAY);
			op(0, 1, 14'h0, y, 4'hf, 0, 0);
			y = fixPar(y);
			j = (w < 9) ? $urandom % (32 / w) : $urandom % (36 / w);
			op(1, 0, 14'(j), 0, 4'hf, 1, slice(y, w, j));
		end
		op(0, 0, 14'h0, 0, 4'hf, 1, x);
		$display("test mixed widths done");
		latB = 1;
		axiW(8'h00, cfgw(2'h2, 3'h5, 3'h5, 1'b0, 1'b0), RESP_OKAY);
		op(0, 1, 14'h3, ~x, 4'hf, 0, 0);
		op(0, 0, 14'h3, 0, 4'hf, 1, x);
		$display("test read only done");
		axiW(8'h00, cfgw(2'h1, 3'h5, 3'h3, 1'b0, 1'b0), RESP_SLVERR);
		axiW(8'h00, cfgw(2'h1, 3'h4, 3'h3, 1'b0, 1'b0), RESP_OKAY);
		x = {$urandom, 4'($urandom)};
		op(1, 1, 14'h8, x, 4'hf, 0, 0);
		op(1, 1, 14'h9, x >> 9, 4'hf, 0, 0);
		op(0, 0, 14'h4, 0, 4'h3, 1, {18'h0, x[17:0]});
		$display("test true dual done");
		op(0, 1, 14'h4, 36'h100, 4'h3, 0, 0);
		axiW(8'h00, cfgw(2'h1, 3'h4, 3'h3, 1'b0, 1'b1), RESP_OKAY);
		op(0, 0, 14'h4, 0, 4'h3, 1, 36'h100);
		axiR(8'h04, 32'h1, RESP_OKAY);
		axiW(8'h04, 32'h1, RESP_OKAY);
		axiR(8'h04, 32'h0, RESP_OKAY);
		$display("test parity check done");
		axiW(8'h00, cfgw(2'h1, 3'h4, 3'h3, 1'b0, 1'b0) | 32'h8000, RESP_OKAY);
		axiR(8'h04, 32'h4, RESP_OKAY);
		axiW(8'h00, cfgw(2'h0, 3'h3, 3'h3, 1'b0, 1'b0), RESP_SLVERR);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		axiR(8'h00, cfgw(2'h0, 3'h3, 3'h3, 1'b0, 1'b0), RESP_OKAY);
		$display("test lock and reset done");
		end_sim();
	end
endmodule // test_embedded_block_ram
